/* src/pis_top.sv */
`timescale 1ns/1ps
`include "pis_defines.svh"

module pis_top (
   input  wire logic                          sys_clk,
   input  wire logic                          rst_n,
   input  wire logic [`PIS_STD_LVL-1:0]       std_req,
   input  wire logic                          std_done,
   input  wire logic [`PIS_PRI_LVL-1:0]       pri_req,
   input  wire logic                          pri_done,
   output logic                               std_enter,
   output logic                               std_return,
   output logic [`PIS_ADDR_W-1:0]             std_addr,
   output logic [`PIS_STD_IDX_W-1:0]          std_level,
   output logic [`PIS_STD_CH_W-1:0]           std_chan,
   output logic                               std_busy,
   output logic                               pri_enter,
   output logic                               pri_return,
   output logic [`PIS_ADDR_W-1:0]             pri_addr,
   output logic [`PIS_PRI_IDX_W-1:0]          pri_level,
   output logic                               pri_busy
);
   import pis_pkg::*;

   pis_regs_t                  r_q;
   pis_regs_t                  r_d;

   logic [`PIS_PRI_LVL-1:0]    pri_rise;
   logic [`PIS_PRI_LVL-1:0]    pri_gmask;
   logic [`PIS_PRI_LVL-1:0]    pri_dmask;
   logic                       pri_grant;
   logic                       pri_pend_found;
   logic [`PIS_PRI_IDX_W-1:0]  pri_pend_idx;
   logic                       pri_act_found;
   logic [`PIS_PRI_IDX_W-1:0]  pri_act_idx;

   logic [`PIS_STD_LVL-1:0]    std_rise;
   logic [`PIS_STD_LVL-1:0]    std_gmask;
   logic [`PIS_STD_LVL-1:0]    std_dmask;
   logic                       std_grant;
   logic                       std_pend_found;
   logic [`PIS_STD_IDX_W-1:0]  std_pend_idx;
   logic                       std_act_found;
   logic [`PIS_STD_IDX_W-1:0]  std_act_idx;

   // Full 1024-wide search; a wide but flat mux tree, traded for no queue RAM
   pis_prio_enc #(.N(`PIS_PRI_LVL), .W(`PIS_PRI_IDX_W)) u_pri_pend (
      .vec   (r_q.pri_pend),
      .found (pri_pend_found),
      .idx   (pri_pend_idx)
   );

   pis_prio_enc #(.N(`PIS_PRI_LVL), .W(`PIS_PRI_IDX_W)) u_pri_act (
      .vec   (r_q.pri_act),
      .found (pri_act_found),
      .idx   (pri_act_idx)
   );

   pis_prio_enc #(.N(`PIS_STD_LVL), .W(`PIS_STD_IDX_W)) u_std_pend (
      .vec   (r_q.std_pend),
      .found (std_pend_found),
      .idx   (std_pend_idx)
   );

   pis_prio_enc #(.N(`PIS_STD_LVL), .W(`PIS_STD_IDX_W)) u_std_act (
      .vec   (r_q.std_act),
      .found (std_act_found),
      .idx   (std_act_idx)
   );

   always_comb begin
      r_d = r_q;

      // Priority set; its state never looks at the standard set
      r_d.pri_s1   = pri_req;
      r_d.pri_s2   = r_q.pri_s1;
      r_d.pri_prev = r_q.pri_s2;
      pri_rise     = r_q.pri_s2 & ~r_q.pri_prev;
      pri_grant    = pri_pend_found && (!pri_act_found || pri_pend_idx < pri_act_idx);
      pri_gmask    = pri_grant ? (`PIS_PRI_LVL'(1) << pri_pend_idx) : '0;
      pri_dmask    = (pri_done && pri_act_found) ? (`PIS_PRI_LVL'(1) << pri_act_idx) : '0;
      // A fresh edge on a level being granted stays queued: set beats clear
      r_d.pri_pend  = (r_q.pri_pend & ~pri_gmask) | pri_rise;
      r_d.pri_act   = (r_q.pri_act & ~pri_dmask) | pri_gmask;
      r_d.pri_wait  = pri_done && pri_act_found;
      r_d.pri_enter = pri_grant;
      r_d.pri_ret   = r_q.pri_wait && pri_act_found && !pri_grant;
      if (pri_grant) begin
         r_d.pri_level = pri_pend_idx;
         r_d.pri_addr  = `PIS_PRI_BASE + {4'h0, pri_pend_idx};
      end else if (r_q.pri_wait && pri_act_found) begin
         r_d.pri_level = pri_act_idx;
         r_d.pri_addr  = `PIS_PRI_BASE + {4'h0, pri_act_idx};
      end
      case (r_q.pri_st)
         PIS_IDLE: begin
            if (pri_grant) begin
               r_d.pri_st = PIS_SERVE;
            end
         end
         PIS_SERVE: begin
            if (r_d.pri_act == '0) begin
               r_d.pri_st = PIS_IDLE;
            end
         end
         default: r_d.pri_st = PIS_IDLE;
      endcase

      // Standard set: level 2c and 2c+1 belong to channel c
      r_d.std_s1   = std_req;
      r_d.std_s2   = r_q.std_s1;
      r_d.std_prev = r_q.std_s2;
      std_rise     = r_q.std_s2 & ~r_q.std_prev;
      std_grant    = std_pend_found && (!std_act_found || std_pend_idx < std_act_idx);
      std_gmask    = std_grant ? (`PIS_STD_LVL'(1) << std_pend_idx) : '0;
      std_dmask    = (std_done && std_act_found) ? (`PIS_STD_LVL'(1) << std_act_idx) : '0;
      r_d.std_pend  = (r_q.std_pend & ~std_gmask) | std_rise;
      r_d.std_act   = (r_q.std_act & ~std_dmask) | std_gmask;
      r_d.std_wait  = std_done && std_act_found;
      r_d.std_enter = std_grant;
      r_d.std_ret   = r_q.std_wait && std_act_found && !std_grant;
      if (std_grant) begin
         r_d.std_level = std_pend_idx;
         r_d.std_chan  = std_pend_idx[`PIS_STD_IDX_W-1:1];
         r_d.std_addr  = `PIS_STD_BASE + {12'h000, std_pend_idx};
      end else if (r_q.std_wait && std_act_found) begin
         r_d.std_level = std_act_idx;
         r_d.std_chan  = std_act_idx[`PIS_STD_IDX_W-1:1];
         r_d.std_addr  = `PIS_STD_BASE + {12'h000, std_act_idx};
      end
      case (r_q.std_st)
         PIS_IDLE: begin
            if (std_grant) begin
               r_d.std_st = PIS_SERVE;
            end
         end
         PIS_SERVE: begin
            if (r_d.std_act == '0) begin
               r_d.std_st = PIS_IDLE;
            end
         end
         default: r_d.std_st = PIS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         r_q        <= '0;
         r_q.pri_st <= PIS_IDLE;
         r_q.std_st <= PIS_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   assign std_enter  = r_q.std_enter;
   assign std_return = r_q.std_ret;
   assign std_addr   = r_q.std_addr;
   assign std_level  = r_q.std_level;
   assign std_chan   = r_q.std_chan;
   assign std_busy   = r_q.std_st[1];
   assign pri_enter  = r_q.pri_enter;
   assign pri_return = r_q.pri_ret;
   assign pri_addr   = r_q.pri_addr;
   assign pri_level  = r_q.pri_level;
   assign pri_busy   = r_q.pri_st[1];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_pri_entry_addr: assert property (
      pri_enter |-> pri_addr == `PIS_PRI_BASE + {4'h0, pri_level})
      else $error("priority entry address not base plus level");

   a_pri_direct_entry: assert property (
      (pri_pend_found && !pri_act_found) |=> pri_enter && pri_level == $past(pri_pend_idx))
      else $error("idle priority request not entered next cycle");

   a_pri_preempt: assert property (
      (pri_pend_found && pri_act_found && pri_pend_idx < pri_act_idx)
      |=> pri_enter ##0 pri_busy)
      else $error("higher priority request did not pre-empt");

   a_pri_queue_low: assert property (
      (pri_pend_found && pri_act_found && pri_pend_idx > pri_act_idx && !pri_done)
      |=> !pri_enter)
      else $error("lower priority request entered while higher active");

   a_pri_auto_return: assert property (
      (pri_done && pri_act_found && !pri_pend_found && $countones(r_q.pri_act) > 1)
      ##1 !pri_pend_found |=> pri_return && pri_level == $past(pri_act_idx))
      else $error("no return to pre-empted priority level");

   a_pri_hold_active: assert property (
      (pri_act_found && !pri_done) |=> pri_act_found && pri_busy)
      else $error("active priority level dropped without completion");

   a_std_chan_pair: assert property (
      std_enter |-> std_chan == std_level[`PIS_STD_IDX_W-1:1])
      else $error("standard level not mapped to its channel");

   a_std_entry_addr: assert property (
      (std_enter || std_return) |-> std_addr == `PIS_STD_BASE + {12'h000, std_level})
      else $error("standard entry address wrong");

   a_sets_indep: assert property (
      (std_grant && !pri_pend_found) |=> std_enter && !pri_enter)
      else $error("standard grant leaked into priority set");

   a_std_preempt: assert property (
      (std_pend_found && std_act_found && std_pend_idx < std_act_idx) |=> std_enter)
      else $error("higher standard level did not pre-empt");

   a_std_queue_low: assert property (
      (std_pend_found && std_act_found && std_pend_idx > std_act_idx && !std_done)
      |=> !std_enter)
      else $error("lower standard request entered while higher active");

endmodule

/* src/pis_defines.svh */
`ifndef PIS_DEFINES_SVH
`define PIS_DEFINES_SVH

// Standard set: two levels for every channel
`define PIS_STD_CH        2
`define PIS_STD_PER_CH    2
`define PIS_STD_LVL       4
`define PIS_STD_IDX_W     2
`define PIS_STD_CH_W      1

// Priority set at its full expansion
`define PIS_PRI_LVL       1024
`define PIS_PRI_IDX_W     10

// Entry points: one memory word per level, base plus level number
`define PIS_ADDR_W        14
`define PIS_STD_BASE      14'h0030
`define PIS_PRI_BASE      14'h0200

`endif

/* src/pis_pkg.sv */
`include "pis_defines.svh"

package pis_pkg;

   typedef enum logic [1:0] {
      PIS_IDLE  = 2'b01,
      PIS_SERVE = 2'b10
   } pis_state_t;

   typedef struct packed {
      logic [`PIS_PRI_LVL-1:0]   pri_s1;
      logic [`PIS_PRI_LVL-1:0]   pri_s2;
      logic [`PIS_PRI_LVL-1:0]   pri_prev;
      logic [`PIS_PRI_LVL-1:0]   pri_pend;
      logic [`PIS_PRI_LVL-1:0]   pri_act;
      logic                      pri_wait;
      logic                      pri_enter;
      logic                      pri_ret;
      logic [`PIS_ADDR_W-1:0]    pri_addr;
      logic [`PIS_PRI_IDX_W-1:0] pri_level;
      pis_state_t                pri_st;
      logic [`PIS_STD_LVL-1:0]   std_s1;
      logic [`PIS_STD_LVL-1:0]   std_s2;
      logic [`PIS_STD_LVL-1:0]   std_prev;
      logic [`PIS_STD_LVL-1:0]   std_pend;
      logic [`PIS_STD_LVL-1:0]   std_act;
      logic                      std_wait;
      logic                      std_enter;
      logic                      std_ret;
      logic [`PIS_ADDR_W-1:0]    std_addr;
      logic [`PIS_STD_IDX_W-1:0] std_level;
      logic [`PIS_STD_CH_W-1:0]  std_chan;
      pis_state_t                std_st;
   } pis_regs_t;

endpackage

/* src/pis_prio_enc.sv */
`timescale 1ns/1ps

// Finds the set bit of lowest index; lower index means higher priority
module pis_prio_enc #(
   parameter int N = 4,
   parameter int W = 2
) (
   input  wire logic [N-1:0] vec,
   output logic              found,
   output logic [W-1:0]      idx
);

   always_comb begin
      found = 1'b0;
      idx   = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (vec[i]) begin
            found = 1'b1;
            idx   = W'(i);
         end
      end
   end

endmodule

/* verif/pis_src.sv */
`timescale 1ns/1ps
`include "pis_defines.svh"

// External source: each commanded request is stretched to two cycles,
// so a single sample by the synchroniser cannot miss it
module pis_src (
   input  wire logic [0:0]              sys_clk,
   input  wire logic [`PIS_STD_LVL-1:0] std_cmd,
   input  wire logic [`PIS_PRI_LVL-1:0] pri_cmd,
   output logic      [`PIS_STD_LVL-1:0] std_req,
   output logic      [`PIS_PRI_LVL-1:0] pri_req
);
   logic [`PIS_STD_LVL-1:0] std_hold_q = '0;
   logic [`PIS_PRI_LVL-1:0] pri_hold_q = '0;

   always @(negedge sys_clk) begin
      std_hold_q <= std_cmd;
      pri_hold_q <= pri_cmd;
   end

   assign std_req = std_cmd | std_hold_q;
   assign pri_req = pri_cmd | pri_hold_q;
endmodule

/* verif/priority_interrupt_system_bench.sv */
`timescale 1ns/1ps
`include "pis_defines.svh"

module priority_interrupt_system_bench;
   logic                        sys_clk  = 1'b0;
   logic                        rst_n    = 1'b0;
   logic [`PIS_STD_LVL-1:0]     std_cmd  = '0;
   logic [`PIS_PRI_LVL-1:0]     pri_cmd  = '0;
   logic                        std_done = 1'b0;
   logic                        pri_done = 1'b0;
   logic [`PIS_STD_LVL-1:0]     std_req;
   logic [`PIS_PRI_LVL-1:0]     pri_req;
   logic                        std_enter, std_return, std_busy;
   logic                        pri_enter, pri_return, pri_busy;
   logic [`PIS_ADDR_W-1:0]      std_addr, pri_addr;
   logic [`PIS_STD_IDX_W-1:0]   std_level;
   logic [`PIS_STD_CH_W-1:0]    std_chan;
   logic [`PIS_PRI_IDX_W-1:0]   pri_level;
   int                          miscompares = 0;
   int                          n_checks = 0;
   int                          pl, lo, mid, hi;

   always #50 sys_clk = ~sys_clk;

   pis_src i_src (.sys_clk(sys_clk), .std_cmd(std_cmd), .pri_cmd(pri_cmd),
                  .std_req(std_req), .pri_req(pri_req));

   pis_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .std_req(std_req), .std_done(std_done),
      .pri_req(pri_req), .pri_done(pri_done), .std_enter(std_enter),
      .std_return(std_return), .std_addr(std_addr), .std_level(std_level),
      .std_chan(std_chan), .std_busy(std_busy), .pri_enter(pri_enter),
      .pri_return(pri_return), .pri_addr(pri_addr), .pri_level(pri_level),
      .pri_busy(pri_busy));

   function automatic logic [13:0] ent(input logic p, input int l);
      return (p ? `PIS_PRI_BASE : `PIS_STD_BASE) + 14'(l);
   endfunction

   task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask

   task automatic entry(input logic p, input int l);
      chk("addr", ent(p, l), p ? pri_addr : std_addr);
      chk("level", 14'(l), p ? 14'(pri_level) : 14'(std_level));
      if (!p) chk("chan", 14'(l / 2), 14'(std_chan));
   endtask

   // Bounded poll: a missing pulse shows up as an event mismatch
   task automatic wait_evt(input logic p, input logic ret, input int l);
      logic hit;
      hit = 1'b0;
      for (int k = 0; k < 8 && hit !== 1'b1; k++) begin
         @(negedge sys_clk);
         hit = p ? (ret ? pri_return : pri_enter) : (ret ? std_return : std_enter);
      end
      chk("event", 14'h1, 14'(hit));
      entry(p, l);
   endtask

   task automatic raise(input logic [3:0] s, input logic [1023:0] p);
      @(negedge sys_clk);
      std_cmd <= s;
      pri_cmd <= p;
      @(negedge sys_clk);
      std_cmd <= '0;
      pri_cmd <= '0;
   endtask

   task automatic fin(input logic s, input logic p);
      @(negedge sys_clk);
      std_done <= s;
      pri_done <= p;
      @(negedge sys_clk);
      std_done <= 1'b0;
      pri_done <= 1'b0;
   endtask

   task automatic end_of_test;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      #(3000 * 100);
      miscompares++;
      end_of_test();
   end

   initial begin
      void'($urandom(32'ha2838a6f));
      repeat (4) @(negedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(negedge sys_clk);
      // Both sets raised together: each must enter on its own
      for (int i = 0; i < 8; i++) begin
         pl = (i == 0) ? 0 : (i == 1) ? 1023 : $urandom_range(1022, 1);
         raise(4'(1) << (i % 4), 1024'(1) << pl);
         wait_evt(1'b0, 1'b0, i % 4);
         chk("pri_enter", 14'h1, 14'(pri_enter));
         entry(1'b1, pl);
         repeat (3) @(negedge sys_clk);
         chk("busy", 14'h3, {12'h0, std_busy, pri_busy});
         fin(1'b1, 1'b1);
         repeat (2) @(negedge sys_clk);
         chk("busy", 14'h0, {12'h0, std_busy, pri_busy});
      end
      lo = $urandom_range(1023, 600);
      mid = $urandom_range(599, 300);
      hi = $urandom_range(299, 0);
      raise('0, 1024'(1) << lo);
      wait_evt(1'b1, 1'b0, lo);
      raise('0, 1024'(1) << hi);
      wait_evt(1'b1, 1'b0, hi);
      raise('0, 1024'(1) << mid);
      for (int k = 0; k < 6; k++) begin
         @(negedge sys_clk);
         chk("pri_enter", 14'h0, 14'(pri_enter));
      end
      fin(1'b0, 1'b1);
      wait_evt(1'b1, 1'b0, mid);
      fin(1'b0, 1'b1);
      wait_evt(1'b1, 1'b1, lo);
      fin(1'b0, 1'b1);
      repeat (2) @(negedge sys_clk);
      chk("pri_busy", 14'h0, 14'(pri_busy));
      raise(4'h8, '0);
      wait_evt(1'b0, 1'b0, 3);
      raise(4'h1, '0);
      wait_evt(1'b0, 1'b0, 0);
      raise(4'h4, '0);
      for (int k = 0; k < 6; k++) begin
         @(negedge sys_clk);
         chk("std_enter", 14'h0, 14'(std_enter));
      end
      fin(1'b1, 1'b0);
      wait_evt(1'b0, 1'b0, 2);
      fin(1'b1, 1'b0);
      wait_evt(1'b0, 1'b1, 3);
      fin(1'b1, 1'b0);
      repeat (2) @(negedge sys_clk);
      chk("std_busy", 14'h0, 14'(std_busy));
      end_of_test();
   end
endmodule
